// ==== idc_pkg.sv ====
package idc_pkg;

	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam int          INSTR_W     = 14;
	localparam int          DATA_W      = 8;
	localparam int          FADDR_W     = 7;
	localparam int          PC_W        = 11;
	localparam int          BSEL_W      = 3;
	localparam int          CLASS_MSB   = 13;
	localparam int          CLASS_LSB   = 12;
	localparam int          CODE_MSB    = 11;
	localparam int          CODE_LSB    = 8;
	localparam int          DEST_BIT    = 7;
	localparam int          BSEL_MSB    = 9;
	localparam int          BSEL_LSB    = 7;
	localparam int          GOTO_BIT    = 11;
	localparam int          STACK_DEPTH = 8;

	// ----------------------------------------
	// instruction classes (top two bits)
	// ----------------------------------------
	localparam logic [1:0]  CLS_BYTE    = 2'h0;
	localparam logic [1:0]  CLS_BIT     = 2'h1;
	localparam logic [1:0]  CLS_BRANCH  = 2'h2;
	localparam logic [1:0]  CLS_LIT     = 2'h3;

	// ----------------------------------------
	// byte-oriented codes
	// ----------------------------------------
	localparam logic [3:0]  BY_MISC     = 4'h0;
	localparam logic [3:0]  BY_CLEAR    = 4'h1;
	localparam logic [3:0]  BY_SUB      = 4'h2;
	localparam logic [3:0]  BY_DEC      = 4'h3;
	localparam logic [3:0]  BY_OR       = 4'h4;
	localparam logic [3:0]  BY_AND      = 4'h5;
	localparam logic [3:0]  BY_XOR      = 4'h6;
	localparam logic [3:0]  BY_ADD      = 4'h7;
	localparam logic [3:0]  BY_MOVE     = 4'h8;
	localparam logic [3:0]  BY_COMP     = 4'h9;
	localparam logic [3:0]  BY_INC      = 4'hA;
	localparam logic [3:0]  BY_DECSZ    = 4'hB;
	localparam logic [3:0]  BY_RRC      = 4'hC;
	localparam logic [3:0]  BY_RLC      = 4'hD;
	localparam logic [3:0]  BY_SWAP     = 4'hE;
	localparam logic [3:0]  BY_INCSZ    = 4'hF;

	// ----------------------------------------
	// misc group low bits (code 0000, bit 7 = 0)
	// ----------------------------------------
	localparam logic [6:0]  MI_RETURN   = 7'h08;
	localparam logic [6:0]  MI_RETURN_FROM_INTERRUPT   = 7'h09;
	localparam logic [6:0]  MI_SLEEP    = 7'h63;
	localparam logic [6:0]  MI_WDCLR    = 7'h64;
	localparam logic [4:0]  MI_NOP_LOW  = 5'h00;

	// ----------------------------------------
	// bit sub-opcodes
	// ----------------------------------------
	localparam logic [1:0]  BI_CLR      = 2'h0;
	localparam logic [1:0]  BI_SET      = 2'h1;
	localparam logic [1:0]  BI_TSTC     = 2'h2;
	localparam logic [1:0]  BI_TSTS     = 2'h3;

	// ----------------------------------------
	// literal codes
	// ----------------------------------------
	localparam logic [3:0]  LI_OR       = 4'h8;
	localparam logic [3:0]  LI_AND      = 4'h9;
	localparam logic [3:0]  LI_XOR      = 4'hA;
	localparam logic [1:0]  LI_LOAD_HI  = 2'h0;
	localparam logic [1:0]  LI_RETL_HI  = 2'h1;
	localparam logic [2:0]  LI_SUB_HI   = 3'h6;
	localparam logic [2:0]  LI_ADD_HI   = 3'h7;

	// ----------------------------------------
	// timing and reset values
	// ----------------------------------------
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          OSC_PER_CYCLE  = 4;
	localparam logic [13:0] NOP_WORD       = 14'h0000;
	localparam logic [10:0] PC_RESET       = 11'h000;
	localparam logic [7:0]  ACC_RESET      = 8'h00;
	localparam logic        TIMEOUT_RESET  = 1'b1;
	localparam logic        PWRDOWN_RESET  = 1'b1;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} idc_phase_t;

	typedef enum logic [3:0] {
		OP_NOP    = 4'b0000,
		OP_BYTE   = 4'b0001,
		OP_CLEAR_REGISTER   = 4'b0010,
		OP_CLEAR_ACCUMULATOR   = 4'b0011,
		OP_STORE_ACCUMULATOR  = 4'b0100,
		OP_BIT    = 4'b0101,
		OP_LIT    = 4'b0110,
		OP_CALL   = 4'b0111,
		OP_GOTO   = 4'b1000,
		OP_RET    = 4'b1001,
		OP_RETURN_FROM_INTERRUPT = 4'b1010,
		OP_RETURN_WITH_LITERAL  = 4'b1011,
		OP_SLEEP  = 4'b1100,
		OP_WDCLR  = 4'b1101
	} idc_op_t;

endpackage

// ==== idc_rf_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface idc_rf_if #(
	parameter int AW = 7,
	parameter int DW = 8
);
	logic [AW-1:0] addr;
	logic          wr_en;
	logic [DW-1:0] wr_data;
	logic [DW-1:0] rd_data;

	modport core (output addr, output wr_en, output wr_data, input rd_data);
	modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

`default_nettype wire

// ==== idc_regfile.sv ====
`timescale 1ns/1ps
`default_nettype none

module idc_regfile #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic clk_i,   // core clock
	input  wire logic ce_i,    // clock enable
	idc_rf_if.mem     rf       // core side
);
	logic [DW-1:0] mem_q [2**AW];
	logic [DW-1:0] rd_q;

	// read first, write later in the same instruction cycle
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			rd_q <= mem_q[rf.addr];
			if (rf.wr_en) begin
				mem_q[rf.addr] <= rf.wr_data;
			end
		end
	end

	assign rf.rd_data = rd_q;
endmodule

`default_nettype wire

// ==== idc_decoder.sv ====
// Notes on behaviour
// - one 14-bit word: opcode plus operand fields
// - destination bit 0 to accumulator, 1 register
// - 7-bit register address in low bits
// - 3-bit field picks bit to change/test
// - 8-bit literals; call/goto prefix 10, 11-bit
// - instruction cycle is four clock periods
// - one cycle; true skip adds nop cycle
// - returns, call, goto take two cycles
// - register read before modify and store
// - byte arithmetic and logic codes with flags
// - inc/dec set Z; skip forms skip zero
// - rotates through carry; swap changes no flag
// - don't-care bits ignored; clear/store/nop encodings
// - bit ops clear, set, test; no flags
// - literal or/and/xor to accumulator, Z only
// - literal add and literal-minus-accumulator, all flags
// - load literal; return with literal, two cycles
// - watchdog clear, sleep, return encodings decoded
// - watchdog clear and sleep clear watchdog counter
// - skip discards fetched word, runs nop
`timescale 1ns/1ps
`default_nettype none

module idc_decoder
	import idc_pkg::*;
#(
	parameter int PCW   = PC_W,
	parameter int DEPTH = STACK_DEPTH
) (
	input  wire logic               clk_i,               // core clock, 10 MHz
	input  wire logic               srst_i,              // sync reset, high
	input  wire logic               ce_i,                // clock enable
	input  wire logic [INSTR_W-1:0] instr_i,             // word at pc_o
	input  wire logic               prescaler_on_wdt_i,  // prescaler assigned to watchdog
	output logic      [PCW-1:0]     pc_o,                // fetch address
	output logic      [DATA_W-1:0]  acc_o,               // accumulator
	output logic                    carry_o,             // C flag
	output logic                    half_carry_flag_o,   // DC flag
	output logic                    zero_o,              // Z flag
	output logic                    timeout_status_o,    // time-out status
	output logic                    powerdown_status_o,  // power-down status
	output logic                    cycle_start_o,       // first period of a cycle
	output logic                    nop_cycle_o,         // current cycle is forced nop
	output logic                    wdt_clear_o,         // watchdog counter clear pulse
	output logic                    prescaler_clear_o,   // prescaler clear pulse
	output logic                    sleep_o,             // sleep entry pulse
	output logic                    int_return_o         // return-from-interrupt pulse
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic idc_op_t decode(input logic [INSTR_W-1:0] w);
		idc_op_t op;
		op = OP_NOP;
		unique case (w[CLASS_MSB:CLASS_LSB])
			CLS_BYTE: begin
				if (w[CODE_MSB:CODE_LSB] == BY_MISC) begin
					if (w[DEST_BIT]) begin
						op = OP_STORE_ACCUMULATOR;
					end else if (w[6:0] == MI_RETURN) begin
						op = OP_RET;
					end else if (w[6:0] == MI_RETURN_FROM_INTERRUPT) begin
						op = OP_RETURN_FROM_INTERRUPT;
					end else if (w[6:0] == MI_SLEEP) begin
						op = OP_SLEEP;
					end else if (w[6:0] == MI_WDCLR) begin
						op = OP_WDCLR;
					end else begin
						op = OP_NOP;
					end
				end else if (w[CODE_MSB:CODE_LSB] == BY_CLEAR) begin
					op = w[DEST_BIT] ? OP_CLEAR_REGISTER : OP_CLEAR_ACCUMULATOR;
				end else begin
					op = OP_BYTE;
				end
			end
			CLS_BIT:    op = OP_BIT;
			CLS_BRANCH: op = w[GOTO_BIT] ? OP_GOTO : OP_CALL;
			CLS_LIT: begin
				if (w[CODE_MSB:CODE_MSB-1] == LI_RETL_HI) begin
					op = OP_RETURN_WITH_LITERAL;
				end else if (w[CODE_MSB:CODE_MSB-1] == LI_LOAD_HI ||
				             w[CODE_MSB:CODE_MSB-2] == LI_SUB_HI ||
				             w[CODE_MSB:CODE_MSB-2] == LI_ADD_HI ||
				             w[CODE_MSB:CODE_LSB] == LI_OR ||
				             w[CODE_MSB:CODE_LSB] == LI_AND ||
				             w[CODE_MSB:CODE_LSB] == LI_XOR) begin
					op = OP_LIT;
				end else begin
					op = OP_NOP;
				end
			end
		endcase
		return op;
	endfunction

	// {half carry, carry, sum}
	function automatic logic [DATA_W+1:0] add8(input logic [DATA_W-1:0] a,
	                                          input logic [DATA_W-1:0] b,
	                                          input logic              cin);
		logic [4:0]        lo;
		logic [DATA_W:0]   full;
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
		return {lo[4], full};
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	idc_phase_t          phase_q;
	logic [INSTR_W-1:0]  ir_q;
	logic                nop_pend_q;
	logic                nop_cyc_q;
	logic [PCW-1:0]      pc_q;
	logic [DATA_W-1:0]   acc_q;
	logic                c_q;
	logic                dc_q;
	logic                z_q;
	logic                to_q;
	logic                pd_q;
	logic                wdclr_q;
	logic                psclr_q;
	logic                sleep_q;
	logic                iret_q;
	logic [PCW-1:0]      stack_q [DEPTH];
	logic [$clog2(DEPTH)-1:0] sp_q;

	idc_rf_if #(.AW(FADDR_W), .DW(DATA_W)) rf ();

	idc_regfile #(
		.AW (FADDR_W),
		.DW (DATA_W)
	) u_rf (
		.clk_i (clk_i),
		.ce_i  (ce_i),
		.rf    (rf.mem)
	);

	// ----------------------------------------
	// fields and execute
	// ----------------------------------------
	idc_op_t            op;
	logic [3:0]         code;
	logic               dest_reg;
	logic [BSEL_W-1:0]  bsel;
	logic [DATA_W-1:0]  k8;
	logic [DATA_W-1:0]  fval;
	logic [DATA_W-1:0]  res;
	logic               wr_acc;
	logic               wr_reg;
	logic               upd_z;
	logic               upd_c;
	logic               upd_dc;
	logic               new_c;
	logic               new_dc;
	logic               skip;
	logic [DATA_W+1:0]  sum;
	logic               ex;

	assign op       = nop_cyc_q ? OP_NOP : decode(ir_q);
	assign code     = ir_q[CODE_MSB:CODE_LSB];
	assign dest_reg = ir_q[DEST_BIT];
	assign bsel     = ir_q[BSEL_MSB:BSEL_LSB];
	assign k8       = ir_q[DATA_W-1:0];
	assign fval     = rf.rd_data;
	assign ex       = ce_i && phase_q == PH_Q4;

	always_comb begin
		res    = fval;
		wr_acc = 1'b0;
		wr_reg = 1'b0;
		upd_z  = 1'b0;
		upd_c  = 1'b0;
		upd_dc = 1'b0;
		new_c  = c_q;
		new_dc = dc_q;
		skip   = 1'b0;
		sum    = '0;
		unique case (op)
			OP_BYTE: begin
				wr_acc = !dest_reg;
				wr_reg = dest_reg;
				upd_z  = 1'b1;
				unique case (code)
					BY_ADD: begin
						sum    = add8(fval, acc_q, 1'b0);
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					BY_SUB: begin
						sum    = add8(fval, ~acc_q, 1'b1);
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					BY_AND:   res = fval & acc_q;
					BY_OR:    res = fval | acc_q;
					BY_XOR:   res = fval ^ acc_q;
					BY_COMP:  res = ~fval;
					BY_MOVE:  res = fval;
					BY_INC:   res = fval + 8'h01;
					BY_DEC:   res = fval - 8'h01;
					BY_INCSZ: begin
						res   = fval + 8'h01;
						upd_z = 1'b0;
						skip  = (res == 8'h00);
					end
					BY_DECSZ: begin
						res   = fval - 8'h01;
						upd_z = 1'b0;
						skip  = (res == 8'h00);
					end
					BY_RLC: begin
						res   = {fval[DATA_W-2:0], c_q};
						new_c = fval[DATA_W-1];
						upd_c = 1'b1;
						upd_z = 1'b0;
					end
					BY_RRC: begin
						res   = {c_q, fval[DATA_W-1:1]};
						new_c = fval[0];
						upd_c = 1'b1;
						upd_z = 1'b0;
					end
					BY_SWAP: begin
						res   = {fval[3:0], fval[7:4]};
						upd_z = 1'b0;
					end
					default: begin
						wr_acc = 1'b0;
						wr_reg = 1'b0;
						upd_z  = 1'b0;
					end
				endcase
				if (code == BY_ADD || code == BY_SUB) begin
					res    = sum[DATA_W-1:0];
					new_c  = sum[DATA_W];
					new_dc = sum[DATA_W+1];
				end
			end
			OP_CLEAR_REGISTER: begin
				res    = 8'h00;
				wr_reg = 1'b1;
				upd_z  = 1'b1;
			end
			OP_CLEAR_ACCUMULATOR: begin
				res    = 8'h00;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_STORE_ACCUMULATOR: begin
				res    = acc_q;
				wr_reg = 1'b1;
			end
			OP_BIT: begin
				unique case (ir_q[CODE_MSB:CODE_MSB-1])
					BI_CLR: begin
						res         = fval;
						res[bsel]   = 1'b0;
						wr_reg      = 1'b1;
					end
					BI_SET: begin
						res         = fval;
						res[bsel]   = 1'b1;
						wr_reg      = 1'b1;
					end
					BI_TSTC: skip = !fval[bsel];
					BI_TSTS: skip = fval[bsel];
				endcase
			end
			OP_LIT: begin
				wr_acc = 1'b1;
				upd_z  = 1'b1;
				if (ir_q[CODE_MSB:CODE_MSB-2] == LI_ADD_HI) begin
					sum    = add8(acc_q, k8, 1'b0);
					res    = sum[DATA_W-1:0];
					new_c  = sum[DATA_W];
					new_dc = sum[DATA_W+1];
					upd_c  = 1'b1;
					upd_dc = 1'b1;
				end else if (ir_q[CODE_MSB:CODE_MSB-2] == LI_SUB_HI) begin
					sum    = add8(k8, ~acc_q, 1'b1);
					res    = sum[DATA_W-1:0];
					new_c  = sum[DATA_W];
					new_dc = sum[DATA_W+1];
					upd_c  = 1'b1;
					upd_dc = 1'b1;
				end else if (code == LI_OR) begin
					res = acc_q | k8;
				end else if (code == LI_AND) begin
					res = acc_q & k8;
				end else if (code == LI_XOR) begin
					res = acc_q ^ k8;
				end else begin
					res   = k8;
					upd_z = 1'b0;
				end
			end
			OP_RETURN_WITH_LITERAL: begin
				res    = k8;
				wr_acc = 1'b1;
			end
			default: begin
				res = fval;
			end
		endcase
	end

	assign rf.addr    = ir_q[FADDR_W-1:0];
	assign rf.wr_en   = ex && wr_reg;
	assign rf.wr_data = res;

	// ----------------------------------------
	// instruction phase and fetch
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			phase_q <= PH_Q1;
		end else if (ce_i) begin
			phase_q <= idc_phase_t'(phase_q + 2'b01);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ir_q      <= NOP_WORD;
			nop_cyc_q <= 1'b1;
		end else if (ce_i && phase_q == PH_Q1) begin
			ir_q      <= nop_pend_q ? NOP_WORD : instr_i;
			nop_cyc_q <= nop_pend_q;
		end
	end

	// ----------------------------------------
	// program counter, stack, second-cycle nop
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pc_q       <= PC_RESET;
			sp_q       <= '0;
			nop_pend_q <= 1'b1;
		end else if (ex) begin
			nop_pend_q <= 1'b0;
			if (nop_cyc_q) begin
				pc_q <= pc_q;
			end else if (op == OP_CALL || op == OP_GOTO) begin
				pc_q       <= ir_q[PCW-1:0];
				nop_pend_q <= 1'b1;
				if (op == OP_CALL) begin
					stack_q[sp_q] <= pc_q + 1'b1;
					sp_q          <= sp_q + 1'b1;
				end
			end else if (op == OP_RET || op == OP_RETURN_FROM_INTERRUPT || op == OP_RETURN_WITH_LITERAL) begin
				pc_q       <= stack_q[sp_q - 1'b1];
				sp_q       <= sp_q - 1'b1;
				nop_pend_q <= 1'b1;
			end else if (skip) begin
				pc_q       <= pc_q + 2'd2;
				nop_pend_q <= 1'b1;
			end else begin
				pc_q <= pc_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// accumulator and flags
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc_q <= ACC_RESET;
			c_q   <= 1'b0;
			dc_q  <= 1'b0;
			z_q   <= 1'b0;
		end else if (ex) begin
			if (wr_acc) begin
				acc_q <= res;
			end
			if (upd_z) begin
				z_q <= (res == 8'h00);
			end
			if (upd_c) begin
				c_q <= new_c;
			end
			if (upd_dc) begin
				dc_q <= new_dc;
			end
		end
	end

	// ----------------------------------------
	// watchdog, sleep and return side effects
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			to_q    <= TIMEOUT_RESET;
			pd_q    <= PWRDOWN_RESET;
			wdclr_q <= 1'b0;
			psclr_q <= 1'b0;
			sleep_q <= 1'b0;
			iret_q  <= 1'b0;
		end else if (ce_i) begin
			wdclr_q <= ex && (op == OP_WDCLR || op == OP_SLEEP);
			psclr_q <= ex && (op == OP_WDCLR || op == OP_SLEEP) && prescaler_on_wdt_i;
			sleep_q <= ex && op == OP_SLEEP;
			iret_q  <= ex && op == OP_RETURN_FROM_INTERRUPT;
			if (ex && op == OP_WDCLR) begin
				to_q <= 1'b1;
				pd_q <= 1'b1;
			end else if (ex && op == OP_SLEEP) begin
				to_q <= 1'b1;
				pd_q <= 1'b0;
			end
		end
	end

	assign pc_o               = pc_q;
	assign acc_o              = acc_q;
	assign carry_o            = c_q;
	assign half_carry_flag_o  = dc_q;
	assign zero_o             = z_q;
	assign timeout_status_o   = to_q;
	assign powerdown_status_o = pd_q;
	assign cycle_start_o      = phase_q == PH_Q1;
	assign nop_cycle_o        = nop_cyc_q;
	assign wdt_clear_o        = wdclr_q;
	assign prescaler_clear_o  = psclr_q;
	assign sleep_o            = sleep_q;
	assign int_return_o       = iret_q;

endmodule

`default_nettype wire

// ==== idc_decoder_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module idc_decoder_asserts
	import idc_pkg::*;
#(
	parameter int PCW = PC_W
) (
	input  wire logic              clk_i,              // core clock
	input  wire logic              srst_i,             // sync reset
	input  wire logic              prescaler_on_wdt_i, // prescaler owner
	input  wire logic [PCW-1:0]    pc_o,               // fetch address
	input  wire logic [DATA_W-1:0] acc_o,              // accumulator
	input  wire logic              carry_o,            // carry flag
	input  wire logic              half_carry_flag_o,  // half carry flag
	input  wire logic              zero_o,             // zero flag
	input  wire logic              powerdown_status_o, // power-down status
	input  wire logic              cycle_start_o,      // first clock of cycle
	input  wire logic              nop_cycle_o,        // forced nop cycle
	input  wire logic              wdt_clear_o,        // watchdog clear pulse
	input  wire logic              prescaler_clear_o,  // prescaler clear pulse
	input  wire logic              sleep_o             // sleep pulse
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_CYCLE_FOUR: assert property (cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
		else $error("instruction cycle not four clocks");
	AST_PC_STABLE: assert property (!cycle_start_o |-> $stable(pc_o))
		else $error("fetch address moved inside a cycle");
	AST_ACC_HOLD: assert property (!cycle_start_o |-> $stable({acc_o, carry_o, half_carry_flag_o, zero_o}))
		else $error("accumulator or flags moved inside a cycle");
	AST_NOP_HOLD: assert property (cycle_start_o && nop_cycle_o && !$past(srst_i) |-> pc_o == $past(pc_o, 4) ##4 !nop_cycle_o)
		else $error("forced nop cycle did not hold the address once");
	AST_PC_STEP: assert property (cycle_start_o && !$past(srst_i) ##4 !nop_cycle_o ##4 !nop_cycle_o |-> $past(pc_o, 4) == $past(pc_o, 8) + 1'b1)
		else $error("plain instruction did not step the address by one");
	AST_WDT_PULSE: assert property (wdt_clear_o |-> cycle_start_o ##1 !wdt_clear_o)
		else $error("watchdog clear pulse misplaced or too long");
	AST_SLEEP_PD: assert property (sleep_o |-> wdt_clear_o && !powerdown_status_o)
		else $error("sleep without watchdog clear or power-down status");
	AST_PRESC: assert property (prescaler_clear_o == (wdt_clear_o && $past(prescaler_on_wdt_i)))
		else $error("prescaler clear does not follow owner and watchdog clear");

	cover property (sleep_o);
	cover property (prescaler_clear_o);
	cover property (cycle_start_o && nop_cycle_o);
endmodule

bind idc_decoder idc_decoder_asserts #(.PCW(PCW)) u_idc_decoder_asserts (
	.clk_i(clk_i), .srst_i(srst_i), .prescaler_on_wdt_i(prescaler_on_wdt_i),
	.pc_o(pc_o), .acc_o(acc_o), .carry_o(carry_o), .half_carry_flag_o(half_carry_flag_o),
	.zero_o(zero_o), .powerdown_status_o(powerdown_status_o), .cycle_start_o(cycle_start_o),
	.nop_cycle_o(nop_cycle_o), .wdt_clear_o(wdt_clear_o), .prescaler_clear_o(prescaler_clear_o),
	.sleep_o(sleep_o)
);

`default_nettype wire

// ==== idc_prog_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module idc_prog_mem
	import idc_pkg::*;
#(
	parameter int PCW = PC_W
) (
	input  wire logic [PCW-1:0]     raddr_i, // fetch address
	output logic      [INSTR_W-1:0] rdata_o  // program word
);
	logic [INSTR_W-1:0] mem_q [2**PCW];

	assign rdata_o = mem_q[raddr_i];
endmodule

`default_nettype wire

// ==== idc_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module idc_decoder_tb;
	import idc_pkg::*;

	// ----------------------------------------
	// program and expected cycle starts {pc, acc, c, dc, z, to, pd, nop}
	// ----------------------------------------
	localparam logic [13:0] PROG [18] = '{14'h330F, 14'h3FF1, 14'h3880, 14'h00A0, 14'h0155,
		14'h0820, 14'h1FA0, 14'h3055, 14'h3AFF, 14'h0064, 14'h0070, 14'h280D, 14'h3055,
		14'h3C80, 14'h0063, 14'h2011, 14'h2810, 14'h345A};
	localparam logic [24:0] EXP [21] = '{{11'd0, 8'h00, 6'b000110}, {11'd1, 8'h0F, 6'b000110},
		{11'd2, 8'h00, 6'b111110}, {11'd3, 8'h80, 6'b110110}, {11'd4, 8'h80, 6'b110110},
		{11'd5, 8'h00, 6'b111110}, {11'd6, 8'h80, 6'b110110}, {11'd8, 8'h80, 6'b110111},
		{11'd8, 8'h80, 6'b110110}, {11'd9, 8'h7F, 6'b110110}, {11'd10, 8'h7F, 6'b110110},
		{11'd11, 8'h7F, 6'b110110}, {11'd13, 8'h7F, 6'b110111}, {11'd13, 8'h7F, 6'b110110},
		{11'd14, 8'h01, 6'b100110}, {11'd15, 8'h01, 6'b100100}, {11'd17, 8'h01, 6'b100101},
		{11'd17, 8'h01, 6'b100100}, {11'd16, 8'h5A, 6'b100101}, {11'd16, 8'h5A, 6'b100100},
		{11'd16, 8'h5A, 6'b100101}};

	logic              clk_i              = 1'b0;
	logic              srst_i             = 1'b1;
	logic              prescaler_on_wdt_i = 1'b0;
	logic [13:0]       instr;
	logic [10:0]       pc;
	logic [7:0]        acc;
	logic              c;
	logic              dc;
	logic              z;
	logic              to;
	logic              pd;
	logic              cs;
	logic              nop;
	logic              nop_due            = 1'b0;
	logic              wdc;
	logic              slp;
	logic              irt;
	int                wdc_n              = 0;
	int                slp_n              = 0;
	int                irt_n              = 0;
	logic [31:0]       rng                = 32'd12;
	logic [24:0]       e;
	logic [24:0]       expq [$];
	int                fail_count         = 0;
	int                comparisons        = 0;
	int                cycles             = 0;

	idc_prog_mem u_idc_prog_mem (.raddr_i(pc), .rdata_o(instr));

	idc_decoder u_idc_decoder (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .instr_i(instr),
		.prescaler_on_wdt_i(prescaler_on_wdt_i), .pc_o(pc), .acc_o(acc),
		.carry_o(c), .half_carry_flag_o(dc), .zero_o(z), .timeout_status_o(to),
		.powerdown_status_o(pd), .cycle_start_o(cs), .nop_cycle_o(nop),
		.wdt_clear_o(wdc), .prescaler_clear_o(), .sleep_o(slp), .int_return_o(irt)
	);

	always #50 clk_i = ~clk_i;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// driver: program load, notes, reset
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 18; i++) begin
			u_idc_prog_mem.mem_q[i] = PROG[i];
		end
		foreach (EXP[i]) begin
			expq.push_back(EXP[i]);
		end
		repeat (8) @(negedge clk_i);
		srst_i <= 1'b0;
		while (expq.size() != 0) begin
			@(negedge clk_i);
		end
		repeat (8) @(negedge clk_i);
		check("wdt_clear_count", 16'(wdc_n), 16'd2);
		check("sleep_count", 16'(slp_n), 16'd1);
		check("int_return_count", 16'(irt_n), 16'd0);
		finish_test();
	end

	always @(negedge clk_i) begin
		if (cs) begin
			rng = xs(rng);
			prescaler_on_wdt_i <= rng[0];
		end
	end

	// ----------------------------------------
	// monitor
	// ----------------------------------------
	always @(negedge clk_i) begin
		cycles++;
		if (cycles > 2000) begin
			fail_count++;
			finish_test();
		end
		if (!srst_i) begin
			wdc_n += int'(wdc);
			slp_n += int'(slp);
			irt_n += int'(irt);
		end
		// nop flag follows the word loaded at the end of the first clock
		if (nop_due) begin
			nop_due = 1'b0;
			check("nop_cycle", 16'(nop), 16'(e[0]));
		end
		if (!srst_i && cs && expq.size() != 0) begin
			e = expq.pop_front();
			nop_due = 1'b1;
			check("pc", 16'(pc), 16'(e[24:14]));
			check("acc_flags", {acc, c, dc, z, to, pd}, e[13:1]);
		end
	end
endmodule

`default_nettype wire
